// *** rtl/gateop_pkg.sv ***
// Constants, register map and carrier types for the gate operator control.
// Assumes a single 50 MHz clock and one Avalon-MM register slave.
// Summary of operation
// (RL1) Open command starts the gate travelling open.
// (RL2) Close command starts the gate travelling closed.
// (RL3) Normally closed stop circuit must be made; opening it halts the motor.
// (RL4) Single-button input advances the command; a switch picks the pattern.
// (RL5) Reverse input while closing runs the gate back to fully open.
// (RL6) Open-obstruction input is honoured only while opening.
// (RL7) First obstruction: stop, back off a short distance, stop again.
// (RL8) After an obstruction stop, no auto close; wait for a new command.
// (RL9) Repeat obstruction before a limit: stop, sound alarm, lock out.
// (RL10) Close-obstruction acts the same, but only while closing.
// (RL11) Hold input at fully open keeps the gate open, blocks closing.
// (RL12) Warning output starts three seconds before motion, or only runs.
// (RL13) Motor current is compared to separate open and close thresholds.
// (RL14) Closing current over threshold counts as obstruction: stop, reverse.
// (RL15) Outside operator presses stop after each current-sense reversal.
// (RL16) Stepped: open, stop, close, stop; else open unless fully open.
// (RL17) Run timer restarts each start, 15..100 s; expiry locks out, alarm.
// (RL18) Contact inputs are synchronised and debounced before use.
package gateop_pkg;
    // ====================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int SEC_CYC = CLK_HZ;
    localparam int DEB_MS = 10;
    localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
    localparam logic [6:0] PREWARN_SEC = 7'h03;
    localparam logic [6:0] BACKOFF_SEC = 7'h01;
    localparam logic [6:0] RUN_MIN_SEC = 7'h0f;
    localparam logic [6:0] RUN_MAX_SEC = 7'h64;
    // ====================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THR_OPEN = 8'h04;
    localparam logic [7:0] OFS_THR_CLOSE = 8'h08;
    localparam logic [7:0] OFS_RUN = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int CTRL_WARN_BIT = 0;
    localparam int CTRL_STEP_BIT = 1;
    localparam int CTRL_AC_BIT = 2;
    localparam int CTRL_UNLOCK_BIT = 3;
    localparam int CTRL_ACSEC_LSB = 8;
    localparam logic [31:0] CTRL_MASK = 32'h00007f07;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [11:0] THR_RST = 12'hfff;
    localparam logic [6:0] RUN_RST = 7'h1e;
    localparam int STAT_ARMED_BIT = 8;
    localparam int STAT_PINS_LSB = 16;
    // ====================================================
    // Types
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WARN = 6'h02,
        ST_OPEN = 6'h04,
        ST_CLOSE = 6'h08,
        ST_BACK = 6'h10,
        ST_LOCK = 6'h20
    } gateop_state_e;
    typedef struct packed {
        logic lim_close;
        logic lim_open;
        logic hold;
        logic obst_close;
        logic obst_open;
        logic reverse;
        logic stop_ok;
        logic single;
        logic close;
        logic open;
    } gateop_pins_s;
endpackage

// *** rtl/gateop_ctrl.sv ***
// Gate operator control: contact inputs, current sense, motor and alarm.
// Assumes contact pins are asynchronous and current_i is sampled on clk_i.
`timescale 1ns/1ps
module gateop_ctrl
    import gateop_pkg::*;
#(
    parameter int SEC_CYC_P = SEC_CYC,
    parameter int DEB_CYC_P = DEB_CYC
)
(
    input wire logic clk_i,              // System clock
    input wire logic reset_i,            // Async reset, active high
    input wire gateop_pins_s pins_i,     // Contact closure inputs
    input wire logic [11:0] current_i,   // Motor current sample
    input wire logic [7:0] address_i,    // Avalon byte address
    input wire logic read_i,             // Avalon read
    input wire logic write_i,            // Avalon write
    input wire logic [31:0] writedata_i, // Avalon write data
    input wire logic [3:0] byteenable_i, // Avalon byte enables
    output logic [31:0] readdata_o,      // Avalon read data
    output logic waitrequest_o,          // Avalon wait request
    output logic motor_open_o,           // Drive gate open
    output logic motor_close_o,          // Drive gate closed
    output logic alarm_o,                // Emergency alarm
    output logic warn_o                  // Strobe or warning device
);
    // ====================================================
    // Functions
    function automatic logic [9:0] agree(input logic [9:0] a,
        input logic [9:0] b, input logic [9:0] old);
        agree = (a & ~(a ^ b)) | (old & (a ^ b));
    endfunction
    function automatic logic [31:0] bmerge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        bmerge = r;
    endfunction

    // ====================================================
    // Input synchroniser and debounce
    logic [9:0] s1_q, s2_q, s3_q, agr_q, smp_q, deb_q, dprev_q;
    logic [19:0] dpre_q;
    wire deb_tick = (dpre_q == 20'(DEB_CYC_P - 1));
    gateop_pins_s db, rs;
    assign db = deb_q;
    assign rs = deb_q & ~dprev_q;
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            agr_q <= '0;
        end
        else
        begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            agr_q <= agree(s2_q, s3_q, agr_q); // RL18
        end
    end

    // A level must hold over two debounce ticks to be believed
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            dpre_q <= '0;
            smp_q <= '0;
            deb_q <= '0;
            dprev_q <= '0;
        end
        else
        begin
            dpre_q <= deb_tick ? 20'h0 : dpre_q + 20'h1;
            if (deb_tick)
            begin
                smp_q <= agr_q;
                deb_q <= agree(agr_q, smp_q, deb_q); // RL18
            end
            dprev_q <= deb_q;
        end
    end

    // ====================================================
    // Registers and bus slave
    logic [31:0] ctrl_q;
    logic [11:0] thr_open_q, thr_close_q;
    logic [6:0] run_sec_q;
    logic unlock_q, wait_q;
    logic [31:0] rdata_q;
    gateop_state_e state_q, state_d;
    logic armed_q, armed_d, dir_q, dir_d;

    wire req = read_i | write_i;
    wire wr_take = write_i & ~waitrequest_o;
    wire wr_ctrl = wr_take & (address_i == OFS_CTRL);
    wire wr_thro = wr_take & (address_i == OFS_THR_OPEN);
    wire wr_thrc = wr_take & (address_i == OFS_THR_CLOSE);
    wire wr_run = wr_take & (address_i == OFS_RUN);
    wire [31:0] ctrl_new = bmerge(ctrl_q, writedata_i, byteenable_i);
    wire [31:0] thro_new = bmerge({20'h0, thr_open_q}, writedata_i,
        byteenable_i);
    wire [31:0] thrc_new = bmerge({20'h0, thr_close_q}, writedata_i,
        byteenable_i);
    wire [6:0] run_in = byteenable_i[0] ? writedata_i[6:0] : run_sec_q;
    wire [6:0] run_new = (run_in < RUN_MIN_SEC) ? RUN_MIN_SEC :
        (run_in > RUN_MAX_SEC) ? RUN_MAX_SEC : run_in;
    wire [31:0] status = {6'h0, deb_q, 7'h0, armed_q, 2'h0, state_q};
    wire [31:0] rd_mux =
        (address_i == OFS_CTRL) ? ctrl_q :
        (address_i == OFS_THR_OPEN) ? {20'h0, thr_open_q} :
        (address_i == OFS_THR_CLOSE) ? {20'h0, thr_close_q} :
        (address_i == OFS_RUN) ? {25'h0, run_sec_q} :
        (address_i == OFS_STATUS) ? status : 32'h0;
    // Seen while idle; gating on waitrequest stops a held request retrigger
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end
        else
        begin
            wait_q <= ~(req & wait_q & waitrequest_o);
            if (read_i & wait_q & waitrequest_o)
                rdata_q <= rd_mux;
        end
    end
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl_q <= CTRL_RST;
            thr_open_q <= THR_RST;
            thr_close_q <= THR_RST;
            run_sec_q <= RUN_RST;
            unlock_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= ctrl_new & CTRL_MASK;
            if (wr_thro)
                thr_open_q <= thro_new[11:0];
            if (wr_thrc)
                thr_close_q <= thrc_new[11:0];
            if (wr_run)
                run_sec_q <= run_new; // RL17
            unlock_q <= wr_ctrl & byteenable_i[0]
                & writedata_i[CTRL_UNLOCK_BIT];
        end
    end

    // ====================================================
    // Command decode
    logic [1:0] step_q;
    logic [25:0] spre_q;
    logic [6:0] sec_q;
    wire warn_mode = ctrl_q[CTRL_WARN_BIT];
    wire stepped = ctrl_q[CTRL_STEP_BIT];
    wire [6:0] ac_sec = ctrl_q[CTRL_ACSEC_LSB +: 7];
    wire sb_open = rs.single & (stepped ? (step_q == 2'h0)
        : ~db.lim_open); // RL16
    wire sb_close = rs.single & (stepped ? (step_q == 2'h2)
        : db.lim_open); // RL16
    wire sb_stop = rs.single & stepped & step_q[0]; // RL16
    wire hold_open = db.hold & db.lim_open; // RL11
    wire open_ev = rs.open | sb_open;
    wire close_ev = (rs.close | sb_close) & ~hold_open; // RL11
    wire over_o = current_i > thr_open_q; // RL13
    wire over_c = current_i > thr_close_q; // RL13
    wire obst_o = db.obst_open | over_o; // RL6
    wire obst_c = db.obst_close | over_c; // RL10 RL14
    wire run_exp = sec_q >= run_sec_q; // RL17
    wire ac_go = ctrl_q[CTRL_AC_BIT] & ~armed_q & db.lim_open
        & ~db.hold & ~db.reverse & ~db.obst_open & ~db.obst_close
        & (sec_q >= ac_sec); // RL8
    wire run_dir = open_ev | ~(close_ev | ac_go);
    wire start = open_ev | close_ev | ac_go;

    // ====================================================
    // Motion state machine
    always_comb
    begin
        state_d = state_q;
        armed_d = armed_q;
        dir_d = dir_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    dir_d = run_dir;
                    state_d = warn_mode ? ST_WARN
                        : (run_dir ? ST_OPEN : ST_CLOSE); // RL1 RL2 RL12
                end
            end
            ST_WARN:
            begin
                if (sb_stop)
                    state_d = ST_IDLE;
                else if (sec_q >= PREWARN_SEC)
                    state_d = dir_q ? ST_OPEN : ST_CLOSE; // RL12
            end
            ST_OPEN:
            begin
                if (obst_o)
                begin
                    state_d = armed_q ? ST_LOCK : ST_BACK; // RL7 RL9
                    armed_d = 1'b1; // RL8
                    dir_d = 1'b0;
                end
                else if (db.lim_open)
                begin
                    state_d = ST_IDLE;
                    armed_d = 1'b0;
                end
                else if (run_exp)
                    state_d = ST_LOCK; // RL17
                else if (close_ev)
                    state_d = ST_CLOSE; // RL2
                else if (sb_stop)
                    state_d = ST_IDLE;
            end
            ST_CLOSE:
            begin
                if (obst_c)
                begin
                    state_d = armed_q ? ST_LOCK : ST_BACK; // RL10 RL14
                    armed_d = 1'b1; // RL8
                    dir_d = 1'b1;
                end
                else if (db.reverse | open_ev)
                    state_d = ST_OPEN; // RL5 RL1
                else if (db.lim_close)
                begin
                    state_d = ST_IDLE;
                    armed_d = 1'b0;
                end
                else if (run_exp)
                    state_d = ST_LOCK; // RL17
                else if (sb_stop)
                    state_d = ST_IDLE;
            end
            ST_BACK:
            begin
                if (sec_q >= BACKOFF_SEC)
                    state_d = ST_IDLE; // RL7
            end
            ST_LOCK:
            begin
                if (unlock_q)
                begin
                    state_d = ST_IDLE;
                    armed_d = 1'b0;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        // Broken stop loop overrides every motion, but not the lockout
        if (!db.stop_ok && state_d != ST_LOCK)
            state_d = ST_IDLE; // RL3
    end

    // Second counter restarts on every state change, so every motor
    // start also restarts the run timer
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            armed_q <= 1'b0;
            dir_q <= 1'b1;
            step_q <= 2'h0;
            spre_q <= '0;
            sec_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            armed_q <= armed_d;
            dir_q <= dir_d;
            if (rs.single & stepped)
                step_q <= step_q + 2'h1; // RL4
            if (state_d != state_q)
            begin
                spre_q <= '0;
                sec_q <= '0;
            end
            else if (spre_q == 26'(SEC_CYC_P - 1))
            begin
                spre_q <= '0;
                if (sec_q != 7'h7f)
                    sec_q <= sec_q + 7'h1;
            end
            else
                spre_q <= spre_q + 26'h1;
        end
    end

    // ====================================================
    // Outputs
    wire back_open = (state_d == ST_BACK) & dir_d;
    wire back_close = (state_d == ST_BACK) & ~dir_d;
    wire run_d = (state_d == ST_OPEN) | (state_d == ST_CLOSE)
        | (state_d == ST_BACK);
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            motor_open_o <= 1'b0;
            motor_close_o <= 1'b0;
            alarm_o <= 1'b0;
            warn_o <= 1'b0;
            readdata_o <= '0;
            waitrequest_o <= 1'b1;
        end
        else
        begin
            motor_open_o <= (state_d == ST_OPEN) | back_open;
            motor_close_o <= (state_d == ST_CLOSE) | back_close;
            alarm_o <= (state_d == ST_LOCK); // RL9 RL17
            warn_o <= run_d | (state_d == ST_WARN); // RL12
            readdata_o <= rdata_q;
            waitrequest_o <= wait_q;
        end
    end
endmodule

// *** testbench/gateop_ctrl_checker.sv ***
// Port checker for gateop_ctrl, attached to the design top by bind.
// Counts follow the second and debounce tick handed in as parameters.
`timescale 1ns/1ps
module gateop_ctrl_checker
    import gateop_pkg::*;
#(
    parameter int SEC_CYC_P = SEC_CYC,
    parameter int DEB_CYC_P = DEB_CYC
)
(
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire gateop_pins_s pins_i, // Contacts
    input wire logic write_i, // Bus write
    input wire logic motor_open_o, // Drive open
    input wire logic motor_close_o, // Drive closed
    input wire logic alarm_o, // Alarm
    input wire logic warn_o // Warning
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // ============================================
    // Run lengths of conditions
    logic run;
    logic mo_q;
    logic [31:0] lo_q, hi_q, hold_q, warn_q, run_q;
    assign run = motor_open_o | motor_close_o;
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            {mo_q, lo_q, hi_q, hold_q, warn_q, run_q} <= '0;
        else
        begin
            mo_q <= motor_open_o;
            lo_q <= pins_i.stop_ok ? '0 : lo_q + 1;
            hi_q <= pins_i.stop_ok ? hi_q + 1 : '0;
            hold_q <= (pins_i.hold & pins_i.lim_open) ? hold_q + 1 : '0;
            warn_q <= (warn_o & ~run) ? warn_q + 1 : '0;
            // A direction change restarts the count like a new start
            run_q <= (run && motor_open_o == mo_q) ? run_q + 1 : '0;
        end
    end
    // ============================================
    // Properties
    property p_stop;
        lo_q > 8 + 3 * DEB_CYC_P |-> !run;
    endproperty
    a_stop: assert property (p_stop) else $error("ran, stop open");
    property p_start;
        $rose(run) |-> hi_q > DEB_CYC_P;
    endproperty
    a_start: assert property (p_start) else $error("early start");
    property p_lock_still;
        alarm_o |-> !run;
    endproperty
    a_lock_still: assert property (p_lock_still) else $error("ran in lock");
    property p_lock_hold;
        alarm_o && !write_i && !$past(write_i) && !$past(write_i, 2)
            |=> alarm_o;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock left");
    property p_warn_run;
        run && $past(run) |-> warn_o;
    endproperty
    a_warn_run: assert property (p_warn_run) else $error("no warn");
    property p_prewarn;
        warn_q <= 32'(PREWARN_SEC) * SEC_CYC_P + 3;
    endproperty
    a_prewarn: assert property (p_prewarn) else $error("long prewarn");
    property p_runmax;
        run_q <= 32'(RUN_MAX_SEC) * SEC_CYC_P + SEC_CYC_P;
    endproperty
    a_runmax: assert property (p_runmax) else $error("run too long");
    property p_hold;
        hold_q > 8 + 3 * DEB_CYC_P |-> !motor_close_o;
    endproperty
    a_hold: assert property (p_hold) else $error("closed on hold");
    c_lock: cover property ($rose(alarm_o));
    c_back: cover property (motor_open_o && $past(motor_close_o));
    c_warn: cover property (warn_o && !run);
endmodule

// *** testbench/gateop_gate_model.sv ***
// Gate with limit switches and a motor current sense.
// Moves one step per cycle of drive; current flows only while driven.
`timescale 1ns/1ps
module gateop_gate_model
#(
    parameter int TRAVEL = 400
)
(
    input wire logic clk_i, // Clock
    input wire logic motor_open_i, // Drive open
    input wire logic motor_close_i, // Drive closed
    input wire logic [11:0] load_i, // Current while driven
    output logic lim_open_o, // Open limit made
    output logic lim_close_o, // Close limit made
    output logic [11:0] current_o // Current sample
);
    int pos = TRAVEL / 2;
    always @(posedge clk_i)
    begin
        // Coasting past a limit is clamped: the switch stays made
        if (motor_open_i && pos < TRAVEL)
            pos <= pos + 1;
        else if (motor_close_i && pos > 0)
            pos <= pos - 1;
    end
    assign lim_open_o = pos >= TRAVEL;
    assign lim_close_o = pos <= 0;
    assign current_o = (motor_open_i | motor_close_i) ? load_i : 12'h000;
endmodule

// *** testbench/gateop_ctrl_test.sv ***
// Bench for gateop_ctrl: Avalon master, contact stimulus, gate model.
// Reads queue expected words; a monitor compares them on completion.
`timescale 1ns/1ps
module gateop_ctrl_test
    import gateop_pkg::*;
;
    localparam logic [35:0] FULL = 36'h0ffffffff;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    gateop_pins_s pins = 10'h008;
    gateop_pins_s pins_w;
    logic lim_o, lim_c, wreq, mo, mc, alarm, warn;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'hf;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [11:0] load = 12'h000;
    logic [11:0] cur;
    logic [11:0] rnd;
    logic [35:0] exp_q[$];
    logic [35:0] msk_q[$];
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 84426;
    logic [5:0] step_st[4] = '{ST_OPEN, ST_IDLE, ST_CLOSE, ST_IDLE};
    logic [3:0] step_o[4] = '{4'h5, 4'h0, 4'h6, 4'h0};
    assign pins_w = gateop_pins_s'({lim_c, lim_o, pins[7:0]});
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    gateop_ctrl #(.SEC_CYC_P(20), .DEB_CYC_P(4)) i_gateop_ctrl (
        .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins_w), .current_i(cur),
        .address_i(addr), .read_i(read), .write_i(write),
        .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata),
        .waitrequest_o(wreq), .motor_open_o(mo), .motor_close_o(mc),
        .alarm_o(alarm), .warn_o(warn));
    gateop_gate_model #(.TRAVEL(400)) i_gateop_gate_model (.clk_i(clk_i),
        .motor_open_i(mo), .motor_close_i(mc), .load_i(load),
        .lim_open_o(lim_o), .lim_close_o(lim_c), .current_o(cur));
    // ============================================
    // Tasks
    task automatic check(input logic [7:0] a, input logic [35:0] s,
        input logic [35:0] e, input logic [35:0] m);
        check_count++;
        if ((s & m) !== (e & m))
        begin
            n_fail++;
            $display("[FAIL] reg %h exp %h seen %h", a, e & m, s & m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] e);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        be <= e;
        read <= ~w;
        write <= w;
        @(posedge clk_i iff wreq === 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [35:0] e,
        input logic [35:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'b0, 32'h00000000, 4'hf);
    endtask
    // Output nibble is alarm, warn, close, open
    task automatic st(input logic [5:0] s, input logic [3:0] o);
        rd(OFS_STATUS, {o, 26'h0000000, s}, {4'hf, 26'h0000000, 6'h3f});
    endtask
    task automatic hit(input int b, input int n, input int t);
        @(posedge clk_i);
        pins[b] <= 1'b1;
        repeat (n) @(posedge clk_i);
        pins[b] <= 1'b0;
        repeat (t) @(posedge clk_i);
    endtask
    task automatic drop();
        @(posedge clk_i);
        pins.stop_ok <= 1'b0;
        repeat (30) @(posedge clk_i);
        pins.stop_ok <= 1'b1;
        repeat (20) @(posedge clk_i);
    endtask
    task automatic settle();
        for (int i = 0; i < 900 && (mo | mc) === 1'b1; i++)
            @(posedge clk_i);
    endtask
    // ============================================
    // Monitor and timeout
    always @(posedge clk_i)
    begin
        if (read === 1'b1 && wreq === 1'b0)
            check(addr, {alarm, warn, mc, mo, rdata}, exp_q.pop_front(),
                msk_q.pop_front());
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    // ============================================
    // Scenarios; pin bits: 0 open 1 close 2 single 4 reverse 5/6 obst
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(OFS_CTRL, {4'h0, CTRL_RST}, FULL);
        rd(OFS_THR_CLOSE, {24'h000000, THR_RST}, FULL);
        rd(OFS_RUN, {29'h00000000, RUN_RST}, FULL);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 36'h000000000, FULL);
        rnd = 12'($random(seed));
        wr(OFS_THR_OPEN, {20'h00000, rnd});
        rd(OFS_THR_OPEN, {24'h000000, rnd}, FULL);
        wr(OFS_RUN, 32'h00000005);
        rd(OFS_RUN, 36'h00000000f, FULL);
        wr(OFS_RUN, 32'h0000007f);
        rd(OFS_RUN, 36'h000000064, FULL);
        bus(OFS_CTRL, 1'b1, 32'hffffffff, 4'h2);
        rd(OFS_CTRL, 36'h000007f00, FULL);
        wr(OFS_CTRL, 32'h00000002);
        for (int i = 0; i < 4; i++)
        begin
            hit(2, 20, 20);
            st(step_st[i], step_o[i]);
        end
        wr(OFS_CTRL, 32'h00000000);
        hit(1, 20, 20);
        st(ST_CLOSE, 4'h6);
        hit(5, 20, 20);
        st(ST_CLOSE, 4'h6);
        drop();
        st(ST_IDLE, 4'h0);
        hit(1, 20, 20);
        hit(4, 20, 20);
        st(ST_OPEN, 4'h5);
        settle();
        pins.hold <= 1'b1;
        hit(1, 20, 20);
        st(ST_IDLE, 4'h0);
        pins.hold <= 1'b0;
        repeat (30) @(posedge clk_i);
        hit(2, 20, 20);
        st(ST_CLOSE, 4'h6);
        hit(2, 20, 20);
        st(ST_OPEN, 4'h5);
        settle();
        hit(1, 20, 20);
        hit(6, 20, 0);
        st(ST_BACK, 4'h5);
        repeat (40) @(posedge clk_i);
        rd(OFS_STATUS, 36'h000000101, 36'hf0000013f);
        hit(1, 20, 20);
        hit(6, 20, 20);
        st(ST_LOCK, 4'h8);
        hit(0, 20, 20);
        st(ST_LOCK, 4'h8);
        wr(OFS_CTRL, 32'h00000008);
        st(ST_IDLE, 4'h0);
        hit(0, 20, 20);
        hit(5, 20, 0);
        st(ST_BACK, 4'h6);
        repeat (40) @(posedge clk_i);
        hit(0, 20, 20);
        settle();
        wr(OFS_THR_OPEN, 32'h00000fff);
        wr(OFS_THR_CLOSE, 32'h00000100);
        load <= 12'h101;
        hit(1, 20, 0);
        st(ST_BACK, 4'h5);
        drop();
        wr(OFS_CTRL, 32'h00000104);
        repeat (40) @(posedge clk_i);
        st(ST_IDLE, 4'h0);
        load <= 12'h100;
        hit(1, 20, 20);
        st(ST_CLOSE, 4'h6);
        hit(0, 20, 20);
        st(ST_OPEN, 4'h5);
        settle();
        repeat (30) @(posedge clk_i);
        st(ST_CLOSE, 4'h6);
        settle();
        wr(OFS_CTRL, 32'h00000001);
        hit(0, 20, 0);
        st(ST_WARN, 4'h4);
        repeat (60) @(posedge clk_i);
        st(ST_OPEN, 4'h5);
        settle();
        wr(OFS_CTRL, 32'h00000000);
        wr(OFS_RUN, 32'h0000000f);
        hit(1, 20, 20);
        st(ST_CLOSE, 4'h6);
        settle();
        st(ST_LOCK, 4'h8);
        wr(OFS_CTRL, 32'h00000008);
        hit(0, 3, 30);
        st(ST_IDLE, 4'h0);
        repeat (2) @(posedge clk_i);
        n_fail += exp_q.size();
        conclude();
    end
endmodule
bind gateop_ctrl gateop_ctrl_checker #(.SEC_CYC_P(SEC_CYC_P),
    .DEB_CYC_P(DEB_CYC_P)) i_gateop_ctrl_checker (.clk_i(clk_i),
    .reset_i(reset_i), .pins_i(pins_i), .write_i(write_i),
    .motor_open_o(motor_open_o), .motor_close_o(motor_close_o),
    .alarm_o(alarm_o), .warn_o(warn_o));
